// *** hdl/ep_irq_flags.sv ***
/*
 * Interrupt flag and mask logic of a USB device controller: endpoint-0
 * control stage flags, endpoint 1-7 transfer-complete flags, per-endpoint
 * zero-length flags, the endpoint mask and two gated interrupt lines.
 * Assumes the packet engine runs on the core clock and sends one-cycle
 * event pulses, and that the command decoder outside sends the
 * setup-finish command as a one-cycle pulse.
 */
// How it works
// RQ1 - Status-done flag sets when endpoint 0's status stage ends well.
// RQ2 - Read ends on a received empty status packet, write on a sent one.
// RQ3 - Status-packet-arrived flag sets on a status packet in a control read.
// RQ4 - Software then issues setup-finish to move from data to status stage.
// RQ5 - Control write ended early: IN token of status stage sets same flag.
// RQ6 - Setup-received flag sets on every SETUP token at endpoint 0.
// RQ7 - Endpoints 1-7 set their transfer-complete bit 7..1 on good transfers.
// RQ8 - Transfer-complete bit reads 0 before data moves, 1 after.
// RQ9 - Mask register holds bits 7..0; 0 passes a flag, 1 blocks it.
// RQ10 - Mask gates transfer flags to one line, zero-length flags to another.
// RQ11 - Masked endpoint still sets transfer bit but does not raise line.
// RQ12 - Masked endpoint still sets zero-length bit but does not raise line.
// RQ13 - Mask bit 0 acts only on the zero-length path.
// RQ14 - Writing one to endpoint summary bit clears the whole event register.
// RQ15 - Endpoint 0 zero-length bit sets in data stage only, never status.
// RQ16 - Endpoint line high while unmasked transfer bit set; all reset to 0.
`timescale 1ns/1ps
module ep_irq_flags
	import ep_irq_pkg::*;
(
	input  wire logic                        I_CORE_CLK,    // Core clock
	input  wire logic                        I_RST_N,       // Sync reset
	input  wire ep_irq_pkg::reg_req_s        I_REG,         // Register port
	output logic [ep_irq_pkg::DATA_W-1:0]    O_RDATA,       // Read data
	input  wire ep_irq_pkg::ep0_evt_s        I_EP0_EVT,     // EP0 events
	input  wire logic                        I_CTRL_READ,   // EP0 is a read
	input  wire logic                        I_SETUP_FIN,   // Setup-finish
	input  wire logic [7:1]                  I_XFER_DONE,   // EP1-7 done
	input  wire logic [7:1]                  I_ZLP_RX,      // EP1-7 zero len
	output logic                             O_SETUP_IRQ,   // Setup flag
	output logic                             O_STAT_PKT_IRQ,// Status packet
	output logic                             O_STAT_END_IRQ,// Status done
	output logic                             O_EP_IRQ,      // Endpoint line
	output logic                             O_RX_ZERO_IRQ, // Zero-len line
	output ep_irq_pkg::ep0_stage_e           O_EP0_STAGE    // EP0 stage
);

	import ep_irq_pkg::*;

	// Register select from a byte address, all zero when unmapped
	function automatic logic [3:0] reg_sel(input logic [ADDR_W-1:0] addr);
		logic [3:0] sel;
		sel = 4'h0;
		if (addr == MAIN_IRQ_OFS) begin
			sel[0] = 1'b1;
		end else if (addr == EP_EVENT_OFS) begin
			sel[1] = 1'b1;
		end else if (addr == EP_MASK_OFS) begin
			sel[2] = 1'b1;
		end else if (addr == RX_ZERO_OFS) begin
			sel[3] = 1'b1;
		end
		return sel;
	endfunction

	// Register port decode, shared by write and read paths
	logic [3:0] addr_sel;
	logic       wr_main;
	logic       wr_event;
	logic       wr_mask;
	logic       wr_rx0;
	logic       rd_hit;

	assign addr_sel = reg_sel(I_REG.addr);

	always_comb begin
		wr_main  = 1'b0;
		wr_event = 1'b0;
		wr_mask  = 1'b0;
		wr_rx0   = 1'b0;
		if (I_REG.wr) begin
			if (addr_sel[0]) begin
				wr_main = 1'b1;
			end else if (addr_sel[1]) begin
				wr_event = 1'b1;
			end else if (addr_sel[2]) begin
				wr_mask = 1'b1;
			end else if (addr_sel[3]) begin
				wr_rx0 = 1'b1;
			end
		end
	end

	// Endpoint-0 stage tracking
	ep0_stage_e stage_q;
	ep0_stage_e stage_d;
	logic       status_pkt_ev;
	logic       status_end_ev;
	logic       ep0_zlp_ev;

	always_comb begin
		stage_d       = stage_q;
		status_pkt_ev = 1'b0;
		status_end_ev = 1'b0;
		ep0_zlp_ev    = 1'b0;
		case (stage_q)
			ST_IDLE: begin
			end
			ST_DATA: begin
				// Read: OUT token means host moved to status
				if (I_EP0_EVT.token && I_CTRL_READ
				    && !I_EP0_EVT.token_in) begin
					status_pkt_ev = 1'b1; // RQ3
				end
				// Write: IN token after data sets the flag; stage stays ST_DATA
				if (I_EP0_EVT.token && !I_CTRL_READ
				    && I_EP0_EVT.token_in) begin
					status_pkt_ev = 1'b1; // RQ5
				end
				// Zero-length data in the data stage only
				if (I_EP0_EVT.pkt_done && I_EP0_EVT.pkt_zero
				    && !I_EP0_EVT.pkt_in) begin
					ep0_zlp_ev = 1'b1; // RQ15
				end
				if (I_SETUP_FIN) begin
					stage_d = ST_STATUS; // RQ4
				end
			end
			ST_STATUS: begin
				// Read ends on a received, write on a sent empty packet
				if (I_EP0_EVT.pkt_done && I_EP0_EVT.pkt_zero
				    && (I_EP0_EVT.pkt_in != I_CTRL_READ)) begin
					status_end_ev = 1'b1; // RQ2
					stage_d       = ST_IDLE;
				end
			end
			default: begin
				stage_d = ST_IDLE;
			end
		endcase
		// A new SETUP restarts the transfer from any stage
		if (I_EP0_EVT.setup_tok) begin
			stage_d = ST_DATA;
		end
	end

	always_ff @(posedge I_CORE_CLK) begin
		if (!I_RST_N) begin
			stage_q <= ST_IDLE;
		end else begin
			stage_q <= stage_d;
		end
	end

	// Main interrupt register flags, write one to clear
	logic setup_q;
	logic stat_pkt_q;
	logic stat_end_q;
	logic ep_sum_q;
	logic rx_sum_q;
	logic main_clr_setup;
	logic main_clr_pkt;
	logic main_clr_end;
	logic main_clr_ep;
	logic main_clr_rx;

	assign main_clr_setup = wr_main && I_REG.wdata[SETUP_BIT];
	assign main_clr_pkt   = wr_main && I_REG.wdata[STATUS_PKT_BIT];
	assign main_clr_end   = wr_main && I_REG.wdata[STATUS_END_BIT];
	assign main_clr_ep    = wr_main && I_REG.wdata[EP_SUM_BIT];
	assign main_clr_rx    = wr_main && I_REG.wdata[RX_ZERO_BIT];

	// Set wins over a clear in the same cycle
	always_ff @(posedge I_CORE_CLK) begin
		if (!I_RST_N) begin
			setup_q <= 1'b0;
		end else begin
			setup_q <= (setup_q & ~main_clr_setup)
			           | I_EP0_EVT.setup_tok; // RQ6
		end
	end

	always_ff @(posedge I_CORE_CLK) begin
		if (!I_RST_N) begin
			stat_pkt_q <= 1'b0;
		end else begin
			stat_pkt_q <= (stat_pkt_q & ~main_clr_pkt)
			              | status_pkt_ev; // RQ3
		end
	end

	always_ff @(posedge I_CORE_CLK) begin
		if (!I_RST_N) begin
			stat_end_q <= 1'b0;
		end else begin
			stat_end_q <= (stat_end_q & ~main_clr_end)
			              | status_end_ev; // RQ1
		end
	end

	// Zero-length events, endpoint 0 gated by stage
	logic [7:0] zlp_set;

	assign zlp_set = {I_ZLP_RX, ep0_zlp_ev};

	always_ff @(posedge I_CORE_CLK) begin
		if (!I_RST_N) begin
			ep_sum_q <= 1'b0;
			rx_sum_q <= 1'b0;
		end else begin
			ep_sum_q <= (ep_sum_q & ~main_clr_ep) | (|I_XFER_DONE);
			rx_sum_q <= (rx_sum_q & ~main_clr_rx) | (|zlp_set);
		end
	end

	// Endpoint event register: bit 0 never sets
	logic [7:0] ev_set;
	logic [7:0] ev_clr;
	logic [7:0] ev_flags;

	assign ev_set = {I_XFER_DONE, 1'b0}; // RQ7
	// Summary write clears every bit; direct write clears per bit
	assign ev_clr = {8{main_clr_ep}}     // RQ14
	                | (wr_event ? I_REG.wdata[7:0] : 8'h00);

	sticky_flags #(
		.WIDTH (EP_COUNT),
		.RST   (FLAGS_RST)
	) u_ev_flags (
		.i_clk   (I_CORE_CLK),
		.i_rst_n (I_RST_N),
		.i_set   (ev_set),
		.i_clr   (ev_clr),
		.o_flags (ev_flags) // RQ8
	);

	// Zero-length received register
	logic [7:0] rx_clr;
	logic [7:0] rx_flags;

	assign rx_clr = {8{main_clr_rx}}
	                | (wr_rx0 ? I_REG.wdata[7:0] : 8'h00);

	sticky_flags #(
		.WIDTH (EP_COUNT),
		.RST   (FLAGS_RST)
	) u_rx_flags (
		.i_clk   (I_CORE_CLK),
		.i_rst_n (I_RST_N),
		.i_set   (zlp_set),
		.i_clr   (rx_clr),
		.o_flags (rx_flags)
	);

	// Endpoint mask register
	logic [7:0] mask_q;

	always_ff @(posedge I_CORE_CLK) begin
		if (!I_RST_N) begin
			mask_q <= MASK_RST; // RQ16
		end else if (wr_mask) begin
			mask_q <= I_REG.wdata[7:0]; // RQ9
		end
	end

	// Mask does not stop flags from setting, only the lines
	logic [7:0] ev_mask;

	// Bit 0 has no transfer flag, so the endpoint path ignores it
	assign ev_mask = {mask_q[7:1], 1'b1}; // RQ13

	mask_gate #(
		.WIDTH (EP_COUNT)
	) u_ep_line (
		.i_clk   (I_CORE_CLK),
		.i_rst_n (I_RST_N),
		.i_flags (ev_flags),
		.i_mask  (ev_mask),
		.o_line  (O_EP_IRQ) // RQ10 RQ11 RQ16
	);

	mask_gate #(
		.WIDTH (EP_COUNT)
	) u_rx_line (
		.i_clk   (I_CORE_CLK),
		.i_rst_n (I_RST_N),
		.i_flags (rx_flags),
		.i_mask  (mask_q),
		.o_line  (O_RX_ZERO_IRQ) // RQ10 RQ12
	);

	// Read data, valid only in the cycle after the read strobe
	logic [DATA_W-1:0] rdata_q;
	logic [DATA_W-1:0] rdata_d;
	logic [DATA_W-1:0] main_word;

	always_comb begin
		main_word                 = RDATA_RST;
		main_word[SETUP_BIT]      = setup_q;
		main_word[STATUS_PKT_BIT] = stat_pkt_q;
		main_word[STATUS_END_BIT] = stat_end_q;
		main_word[RX_ZERO_BIT]    = rx_sum_q;
		main_word[EP_SUM_BIT]     = ep_sum_q;
	end

	always_comb begin
		rdata_d = RDATA_RST;
		rd_hit  = 1'b0;
		if (I_REG.rd) begin
			if (addr_sel[0]) begin
				rdata_d = main_word;
				rd_hit  = 1'b1;
			end else if (addr_sel[1]) begin
				rdata_d = {24'h00_0000, ev_flags};
				rd_hit  = 1'b1;
			end else if (addr_sel[2]) begin
				rdata_d = {24'h00_0000, mask_q};
				rd_hit  = 1'b1;
			end else if (addr_sel[3]) begin
				rdata_d = {24'h00_0000, rx_flags};
				rd_hit  = 1'b1;
			end
		end
		// Unmapped reads answer zero
		if (!rd_hit) begin
			rdata_d = RDATA_RST;
		end
	end

	always_ff @(posedge I_CORE_CLK) begin
		if (!I_RST_N) begin
			rdata_q <= RDATA_RST;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	assign O_RDATA        = rdata_q;
	assign O_SETUP_IRQ    = setup_q;
	assign O_STAT_PKT_IRQ = stat_pkt_q;
	assign O_STAT_END_IRQ = stat_end_q;
	assign O_EP0_STAGE    = stage_q;

endmodule

// *** hdl/ep_irq_pkg.sv ***
/*
 * Shared constants and carriers for the endpoint interrupt flag block:
 * register offsets, field positions, reset values and the endpoint-0
 * event bundle.
 * Assumes a 32-bit word register port with byte addresses.
 */
package ep_irq_pkg;

	localparam int unsigned DATA_W   = 32;
	localparam int unsigned ADDR_W   = 8;
	localparam int unsigned EP_COUNT = 8;

	// Register byte offsets
	localparam logic [7:0] MAIN_IRQ_OFS = 8'h00;
	localparam logic [7:0] EP_EVENT_OFS = 8'h04;
	localparam logic [7:0] EP_MASK_OFS  = 8'h08;
	localparam logic [7:0] RX_ZERO_OFS  = 8'h0c;

	// Main interrupt register bit positions
	localparam int unsigned SETUP_BIT      = 0;
	localparam int unsigned STATUS_PKT_BIT = 1;
	localparam int unsigned STATUS_END_BIT = 2;
	localparam int unsigned RX_ZERO_BIT    = 3;
	localparam int unsigned EP_SUM_BIT     = 6;

	// Transfer-complete bits occupy 7..1 of the event register
	localparam int unsigned EP_FIRST = 1;

	// Values after reset
	localparam logic [7:0]  FLAGS_RST = 8'h00;
	localparam logic [7:0]  MASK_RST  = 8'h00;
	localparam logic [31:0] RDATA_RST = 32'h0000_0000;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_DATA,
		ST_STATUS
	} ep0_stage_e;

	// Endpoint-0 events from the packet engine, one-cycle pulses
	typedef struct packed {
		logic setup_tok;  // SETUP token taken
		logic token;      // IN or OUT token taken
		logic token_in;   // 1: IN token, 0: OUT token
		logic pkt_done;   // Packet handshake finished well
		logic pkt_in;     // 1: device sent it, 0: device received it
		logic pkt_zero;   // Packet had zero length
	} ep0_evt_s;

	// Register port request
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic              wr;
		logic              rd;
	} reg_req_s;

endpackage

// *** hdl/sticky_flags.sv ***
/*
 * Bank of sticky flags: hardware sets, software clears by writing one.
 * Assumes set and clear pulses are on the same clock.
 */
`timescale 1ns/1ps
module sticky_flags #(
	parameter int unsigned           WIDTH = 8,
	parameter logic [WIDTH-1:0]      RST   = '0
) (
	input  wire logic             i_clk,    // Core clock
	input  wire logic             i_rst_n,  // Sync reset, active low
	input  wire logic [WIDTH-1:0] i_set,    // Set pulses
	input  wire logic [WIDTH-1:0] i_clr,    // Clear pulses
	output logic      [WIDTH-1:0] o_flags   // Flag state
);

	logic [WIDTH-1:0] flags_q;
	logic [WIDTH-1:0] flags_d;

	// A set in the clearing cycle is kept
	assign flags_d = (flags_q & ~i_clr) | i_set;

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			flags_q <= RST;
		end else begin
			flags_q <= flags_d;
		end
	end

	assign o_flags = flags_q;

endmodule

// *** hdl/mask_gate.sv ***
/*
 * Gates flags by mask bits (0 passes, 1 blocks) onto one registered line.
 * Assumes flags and mask share the core clock.
 */
`timescale 1ns/1ps
module mask_gate #(
	parameter int unsigned WIDTH = 8
) (
	input  wire logic             i_clk,    // Core clock
	input  wire logic             i_rst_n,  // Sync reset, active low
	input  wire logic [WIDTH-1:0] i_flags,  // Flags to gate
	input  wire logic [WIDTH-1:0] i_mask,   // 1 blocks the flag
	output logic                  o_line    // Registered interrupt line
);

	logic line_q;

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			line_q <= 1'b0;
		end else begin
			line_q <= |(i_flags & ~i_mask);
		end
	end

	assign o_line = line_q;

endmodule

// *** verif/ep_irq_monitor.sv ***
/* Port checks for the endpoint interrupt flag block.
   Bound to ep_irq_flags; one core clock, sync active-low reset. */
`timescale 1ns/1ps
module ep_irq_monitor
	import ep_irq_pkg::*;
(
	input wire logic                     I_CORE_CLK,     // Clock
	input wire logic                     I_RST_N,        // Reset
	input wire ep_irq_pkg::reg_req_s     I_REG,          // Register port
	input wire logic [DATA_W-1:0]        O_RDATA,        // Read data
	input wire ep_irq_pkg::ep0_evt_s     I_EP0_EVT,      // EP0 events
	input wire logic                     I_CTRL_READ,    // Read transfer
	input wire logic                     I_SETUP_FIN,    // Setup-finish
	input wire logic [7:1]               I_XFER_DONE,    // Transfer done
	input wire logic [7:1]               I_ZLP_RX,       // Zero length
	input wire logic                     O_SETUP_IRQ,    // Setup flag
	input wire logic                     O_STAT_PKT_IRQ, // Status packet
	input wire logic                     O_STAT_END_IRQ, // Status done
	input wire logic                     O_EP_IRQ,       // Endpoint line
	input wire logic                     O_RX_ZERO_IRQ,  // Zero line
	input wire ep_irq_pkg::ep0_stage_e   O_EP0_STAGE     // Stage
);
	wire logic mask_wr = I_REG.wr && I_REG.addr == EP_MASK_OFS;
	wire logic no_setup = !I_EP0_EVT.setup_tok;
	default clocking cb @(posedge I_CORE_CLK); endclocking
	default disable iff (!I_RST_N);
	sequence s_in_data;
		O_SETUP_IRQ && O_EP0_STAGE == ST_DATA;
	endsequence
	sequence s_back_idle;
		O_STAT_END_IRQ && O_EP0_STAGE == ST_IDLE;
	endsequence
	property p_setup;
		I_EP0_EVT.setup_tok |=> s_in_data;
	endproperty
	property p_stat_pkt;
		O_EP0_STAGE == ST_DATA && I_EP0_EVT.token
			&& I_EP0_EVT.token_in != I_CTRL_READ |=> O_STAT_PKT_IRQ;
	endproperty
	property p_pkt_data;
		$rose(O_STAT_PKT_IRQ) |-> $past(O_EP0_STAGE) == ST_DATA;
	endproperty
	property p_fin;
		O_EP0_STAGE == ST_DATA && I_SETUP_FIN && no_setup
			|=> O_EP0_STAGE == ST_STATUS;
	endproperty
	property p_stat_end;
		O_EP0_STAGE == ST_STATUS && I_EP0_EVT.pkt_done && no_setup
			&& I_EP0_EVT.pkt_zero && I_EP0_EVT.pkt_in != I_CTRL_READ
			|=> s_back_idle;
	endproperty
	property p_end_status;
		$rose(O_STAT_END_IRQ) |-> $past(O_EP0_STAGE) == ST_STATUS;
	endproperty
	property p_ep_rise;
		$rose(O_EP_IRQ) |-> $past(|I_XFER_DONE, 2) || $past(mask_wr, 2);
	endproperty
	property p_ep_fall;
		$fell(O_EP_IRQ) |-> $past(I_REG.wr, 2);
	endproperty
	property p_zero_rise;
		$rose(O_RX_ZERO_IRQ) |-> $past(|I_ZLP_RX, 2)
			|| $past(I_EP0_EVT.pkt_done, 2) || $past(mask_wr, 2);
	endproperty
	property p_ev_bits;
		I_REG.rd && I_REG.addr == EP_EVENT_OFS
			|=> O_RDATA[0] == 1'b0 && O_RDATA[31:8] == 24'h0;
	endproperty
	a_setup: assert property (p_setup) else $error("setup flag");
	a_stat_pkt: assert property (p_stat_pkt) else $error("pkt");
	a_pkt_data: assert property (p_pkt_data) else $error("pkt");
	a_fin: assert property (p_fin) else $error("finish");
	a_stat_end: assert property (p_stat_end) else $error("end");
	a_end_status: assert property (p_end_status) else $error("end");
	a_ep_rise: assert property (p_ep_rise) else $error("ep up");
	a_ep_fall: assert property (p_ep_fall) else $error("ep down");
	a_zero_rise: assert property (p_zero_rise) else $error("zl");
	a_ev_bits: assert property (p_ev_bits) else $error("bits");
endmodule
bind ep_irq_flags ep_irq_monitor u_ep_irq_monitor (
	.I_CORE_CLK(I_CORE_CLK), .I_RST_N(I_RST_N), .I_REG(I_REG),
	.O_RDATA(O_RDATA), .I_EP0_EVT(I_EP0_EVT), .I_CTRL_READ(I_CTRL_READ),
	.I_SETUP_FIN(I_SETUP_FIN), .I_XFER_DONE(I_XFER_DONE),
	.I_ZLP_RX(I_ZLP_RX), .O_SETUP_IRQ(O_SETUP_IRQ),
	.O_STAT_PKT_IRQ(O_STAT_PKT_IRQ), .O_STAT_END_IRQ(O_STAT_END_IRQ),
	.O_EP_IRQ(O_EP_IRQ), .O_RX_ZERO_IRQ(O_RX_ZERO_IRQ),
	.O_EP0_STAGE(O_EP0_STAGE)
);

// *** verif/usb_host_model.sv ***
/* Host-side event source: one-cycle packet engine pulses.
   Assumes callers start each task right after a rising edge. */
`timescale 1ns/1ps
module usb_host_model
	import ep_irq_pkg::*;
(
	input  wire logic            i_clk,       // Core clock
	output ep_irq_pkg::ep0_evt_s o_evt,       // EP0 events
	output logic                 o_ctrl_read, // Read transfer
	output logic [7:1]           o_xfer,      // Transfer done
	output logic [7:1]           o_zlp        // Zero length
);
	initial begin
		o_evt = '0;
		o_ctrl_read = 1'b0;
		o_xfer = '0;
		o_zlp = '0;
	end
	task automatic mode(input logic r);
		o_ctrl_read <= r;
	endtask
	task automatic ep0(input logic [5:0] e);
		o_evt <= ep0_evt_s'(e);
		@(posedge i_clk);
		o_evt <= '0;
		@(posedge i_clk);
	endtask
	task automatic pulse(input logic [7:1] x, input logic [7:1] z);
		o_xfer <= x;
		o_zlp <= z;
		@(posedge i_clk);
		o_xfer <= '0;
		o_zlp <= '0;
		@(posedge i_clk);
	endtask
	// Data ended by a zero-length packet, then the status IN token
	task automatic end_write_data();
		ep0(6'h05);
		ep0(6'h18);
	endtask
endmodule

// *** verif/testbench.sv ***
/* Self-checking bench for the endpoint interrupt flag block.
   Drives the register port and setup-finish; host model sends events. */
`timescale 1ns/1ps
module testbench;
	import ep_irq_pkg::*;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	reg_req_s    rq = '0;
	logic        fin = 1'b0;
	ep0_evt_s    evt;
	logic        ctrl_read;
	logic [7:1]  xfer;
	logic [7:1]  zlp;
	logic [31:0] rdata;
	logic        ep_line;
	logic        zero_line;
	logic        setup_irq;
	logic        stat_pkt;
	logic        stat_end;
	ep0_stage_e  stage;
	int          n_fail = 0;
	int          samples_checked = 0;
	int          cyc = 0;
	initial forever #5 clk = ~clk;
	ep_irq_flags u_ep_irq_flags (.I_CORE_CLK(clk), .I_RST_N(rst_n),
		.I_REG(rq), .O_RDATA(rdata), .I_EP0_EVT(evt),
		.I_CTRL_READ(ctrl_read), .I_SETUP_FIN(fin), .I_XFER_DONE(xfer),
		.I_ZLP_RX(zlp), .O_SETUP_IRQ(setup_irq),
		.O_STAT_PKT_IRQ(stat_pkt), .O_STAT_END_IRQ(stat_end),
		.O_EP_IRQ(ep_line), .O_RX_ZERO_IRQ(zero_line),
		.O_EP0_STAGE(stage));
	usb_host_model u_usb_host_model (.i_clk(clk), .o_evt(evt),
		.o_ctrl_read(ctrl_read), .o_xfer(xfer), .o_zlp(zlp));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
			n_fail++;
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		rq <= '{a, d, 1'b1, 1'b0};
		@(posedge clk);
		rq <= '0;
		@(posedge clk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		rq <= '{a, 32'h0, 1'b0, 1'b1};
		@(posedge clk);
		rq <= '0;
		#1;
		chk(rdata, exp);
		@(posedge clk);
	endtask
	task automatic lines(input logic ep, input logic zero);
		#1;
		chk(32'(ep_line), 32'(ep));
		chk(32'(zero_line), 32'(zero));
		@(posedge clk);
	endtask
	task automatic flags(input logic [2:0] f, input ep0_stage_e s);
		#1;
		chk(32'({stat_end, stat_pkt, setup_irq}), 32'(f));
		chk(32'(stage), 32'(s));
		@(posedge clk);
	endtask
	task automatic setup_fin();
		fin <= 1'b1;
		@(posedge clk);
		fin <= 1'b0;
		@(posedge clk);
	endtask
	task automatic t_regs();
		flags(3'b000, ST_IDLE);
		rd(EP_EVENT_OFS, 32'h0);
		rd(MAIN_IRQ_OFS, 32'h0);
		rd(EP_MASK_OFS, 32'h0);
		rd(RX_ZERO_OFS, 32'h0);
		wr(EP_MASK_OFS, 32'h0000_01ff);
		rd(EP_MASK_OFS, 32'h0000_00ff);
		rd(8'h10, 32'h0);
		wr(EP_MASK_OFS, 32'h0);
		$display("test regs done");
	endtask
	task automatic t_ctrl_read();
		u_usb_host_model.mode(1'b1);
		u_usb_host_model.ep0(6'h10);
		flags(3'b000, ST_IDLE);
		u_usb_host_model.ep0(6'h20);
		flags(3'b001, ST_DATA);
		u_usb_host_model.ep0(6'h10);
		flags(3'b011, ST_DATA);
		setup_fin();
		flags(3'b011, ST_STATUS);
		u_usb_host_model.ep0(6'h07);
		flags(3'b011, ST_STATUS);
		u_usb_host_model.ep0(6'h05);
		flags(3'b111, ST_IDLE);
		rd(MAIN_IRQ_OFS, 32'h7);
		rd(RX_ZERO_OFS, 32'h0);
		wr(MAIN_IRQ_OFS, 32'h7);
		rd(MAIN_IRQ_OFS, 32'h0);
		$display("test control read done");
	endtask
	task automatic t_ctrl_write();
		u_usb_host_model.mode(1'b0);
		wr(EP_MASK_OFS, 32'h1);
		u_usb_host_model.ep0(6'h20);
		u_usb_host_model.end_write_data();
		lines(1'b0, 1'b0);
		flags(3'b011, ST_DATA);
		wr(EP_MASK_OFS, 32'h0);
		lines(1'b0, 1'b1);
		rd(RX_ZERO_OFS, 32'h1);
		setup_fin();
		u_usb_host_model.ep0(6'h07);
		flags(3'b111, ST_IDLE);
		rd(MAIN_IRQ_OFS, 32'hf);
		wr(MAIN_IRQ_OFS, 32'h8);
		lines(1'b0, 1'b0);
		rd(RX_ZERO_OFS, 32'h0);
		wr(MAIN_IRQ_OFS, 32'h7);
		flags(3'b000, ST_IDLE);
		$display("test control write done");
	endtask
	task automatic t_xfer();
		for (int n = 1; n < 8; n++) begin
			u_usb_host_model.pulse(7'(1 << (n - 1)), 7'h0);
			lines(1'b1, 1'b0);
			rd(EP_EVENT_OFS, 32'(1 << n));
			wr(EP_EVENT_OFS, 32'(1 << n));
			lines(1'b0, 1'b0);
		end
		// Set and clear of one bit in the same cycle: set is kept
		fork
			u_usb_host_model.pulse(7'h01, 7'h0);
			wr(EP_EVENT_OFS, 32'h2);
		join
		rd(EP_EVENT_OFS, 32'h2);
		wr(EP_EVENT_OFS, 32'h2);
		lines(1'b0, 1'b0);
		wr(EP_MASK_OFS, 32'hfe);
		u_usb_host_model.pulse(7'h7f, 7'h0);
		lines(1'b0, 1'b0);
		rd(EP_EVENT_OFS, 32'hfe);
		wr(EP_MASK_OFS, 32'h1);
		lines(1'b1, 1'b0);
		wr(MAIN_IRQ_OFS, 32'h40);
		lines(1'b0, 1'b0);
		rd(EP_EVENT_OFS, 32'h0);
		wr(EP_MASK_OFS, 32'hff);
		u_usb_host_model.pulse(7'h0, 7'h7f);
		lines(1'b0, 1'b0);
		rd(RX_ZERO_OFS, 32'hfe);
		wr(EP_MASK_OFS, 32'hfd);
		lines(1'b0, 1'b1);
		$display("test endpoint flags done");
	endtask
	task automatic report_and_stop();
		$display("checks=%0d mismatches=%0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			n_fail++;
			report_and_stop();
		end
	end
	initial begin
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		t_regs();
		t_ctrl_read();
		t_ctrl_write();
		t_xfer();
		report_and_stop();
	end
endmodule
